/* src/rcg_consts.svh */
`ifndef RCG_CONSTS_SVH
`define RCG_CONSTS_SVH

// Register word indices (byte address = 4 * index)
`define RCG_REG_CTRL 6'h00
`define RCG_REG_STATUS 6'h01
`define RCG_REG_IRQ_STAT 6'h02
`define RCG_REG_IRQ_MASK 6'h03
`define RCG_MAP_BASE_BIT 5

// Control register fields
`define RCG_CTRL_REMOTE 0
`define RCG_CTRL_VIRT_IO 1
`define RCG_CTRL_RESET 2'h0

// Map entry layout: enable bit above a 5-bit I/O number
`define RCG_MAP_EN 5
`define RCG_MAP_UNSET 6'h00

// Function slots in the map table
`define RCG_FN_RUN 0
`define RCG_FN_SEL0 1
`define RCG_FN_ABORT 7
`define RCG_FN_SUSPEND 8
`define RCG_FN_RESUME 9
`define RCG_FN_RESET 10
`define RCG_FN_OUT0 16
`define RCG_FN_OUT_CNT 10

// Default map entries after configuration reset
`define RCG_DEF_RUN 6'h20
`define RCG_DEF_W1 6'h21
`define RCG_DEF_W2 6'h22
`define RCG_DEF_W4 6'h23
`define RCG_DEF_ABORT 6'h24
`define RCG_DEF_SUSPEND 6'h25
`define RCG_DEF_RESUME 6'h26
`define RCG_DEF_RESET 6'h27
`define RCG_DEF_READY 6'h20
`define RCG_DEF_RUNNING 6'h21
`define RCG_DEF_PAUSED 6'h22
`define RCG_DEF_ERROR 6'h23
`define RCG_DEF_GUARD 6'h25
`define RCG_DEF_SERIOUS 6'h26
`define RCG_DEF_WARNING 6'h27
`define RCG_DEF_RELEASED 6'h28

// Interrupt status bits
`define RCG_IRQ_RUN 0
`define RCG_IRQ_ABORT 1
`define RCG_IRQ_SUSPEND 2
`define RCG_IRQ_RESUME 3
`define RCG_IRQ_RESET 4
`define RCG_IRQ_REJECT 5
`define RCG_IRQ_RESET_VAL 6'h00

// Status register program number field
`define RCG_STAT_PROG_LSB 16

`endif

/* src/rcg_edge_sync.sv */
`timescale 1ns/1ps
module rcg_edge_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw discrete inputs
  input wire rcg_pkg::rcg_din_t din_i,
  // Synchronised levels and rising-edge pulses
  output rcg_pkg::rcg_din_t level_o,
  output rcg_pkg::rcg_din_t rise_o
);
  import rcg_pkg::*;

  rcg_din_t meta;
  rcg_din_t stable;
  rcg_din_t prev;

  // Two-stage synchroniser, then one more stage for edge detection
  genvar g;
  generate
    for (g = 0; g < 24; g = g + 1) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta[g] <= 1'b0;
          stable[g] <= 1'b0;
          prev[g] <= 1'b0;
        end else begin
          meta[g] <= din_i[g];
          stable[g] <= meta[g];
          prev[g] <= stable[g];
        end
      end
    end
  endgenerate

  // Edge is a single-cycle pulse from stable stages only
  assign level_o = stable;
  assign rise_o = stable & ~prev;
endmodule

/* src/rcg_gate.sv */
`timescale 1ns/1ps
`include "rcg_consts.svh"
module rcg_gate (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Discrete I/O lines
  input wire rcg_pkg::rcg_din_t din_i,
  output rcg_pkg::rcg_dout_t dout_o,
  // Controller status
  input wire logic ready_i,
  input wire logic running_i,
  input wire logic paused_i,
  input wire logic error_i,
  input wire logic halt_active_status_i,
  input wire logic guard_open_status_i,
  input wire logic serious_fault_status_i,
  input wire logic warning_i,
  input wire logic halt_released_status_i,
  // Command pulses to the controller
  output logic run_req_o,
  output rcg_pkg::rcg_prog_t run_prog_o,
  output logic abort_o,
  output logic suspend_o,
  output logic resume_o,
  output logic fault_reset_o,
  // Status and interrupt
  output logic external_control_active_o,
  output logic command_rejected_flag_o,
  output logic irq_o
);
  import rcg_pkg::*;

  // Bus side state
  rcg_bus_e bus_state;
  logic [1:0] ctrl;
  rcg_irq_t irq_stat;
  rcg_irq_t irq_mask;
  logic [5:0] word_idx;
  logic map_hit;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] next_rdata;

  // Map table
  logic [191:0] map_table;
  rcg_map_t map_rdata;

  // Input path
  rcg_din_t lvl;
  rcg_din_t rise;
  logic remote_on;
  logic run_edge;
  logic abort_edge;
  logic suspend_edge;
  logic resume_edge;
  logic reset_edge;
  logic abort_lvl;
  logic suspend_lvl;
  rcg_prog_t prog_now;
  logic run_ok;
  logic suspend_ok;
  logic resume_ok;
  logic reset_ok;
  logic any_accept;
  logic any_reject;
  logic [`RCG_FN_OUT_CNT-1:0] out_src;
  rcg_dout_t next_dout;
  rcg_irq_t irq_evt;

  // Slot entry from the flat table
  function automatic rcg_map_t slot(input logic [191:0] tbl, input int idx);
    slot = tbl[idx*6 +: 6];
  endfunction

  // Line value of a mapped function; an unmapped one reads low
  function automatic logic pick(input rcg_map_t ent, input rcg_din_t vec);
    pick = ent[`RCG_MAP_EN] && vec[ent[4:0]];
  endfunction

  // True when an output slot is routed to the given pin
  function automatic logic routes_to(input rcg_map_t ent, input int pin);
    routes_to = ent[`RCG_MAP_EN] && (ent[4:0] == 5'(pin));
  endfunction

  // Synchroniser and edge detector for all discrete inputs
  rcg_edge_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .din_i(din_i),
    .level_o(lvl),
    .rise_o(rise)
  );

  // Function to pin assignment table, defaults loaded at reset
  rcg_map_regs u_map (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(bus_wr && map_hit),
    .waddr_i(word_idx[4:0]),
    .wdata_i(wb_dat_i[5:0]),
    .raddr_i(word_idx[4:0]),
    .rdata_o(map_rdata),
    .table_o(map_table)
  );

  // Bus address decode
  assign word_idx = wb_adr_i[7:2];
  assign map_hit = word_idx[`RCG_MAP_BASE_BIT];
  assign bus_wr = (bus_state == BUS_WAIT) && wb_we_i && wb_sel_i[0];
  assign bus_rd = (bus_state == BUS_WAIT) && !wb_we_i;

  // Remote source only; the virtual I/O bit deliberately plays no part
  assign remote_on = ctrl[`RCG_CTRL_REMOTE];

  // Command edges, gated by remote mode and mapping
  assign run_edge = remote_on && pick(slot(map_table, `RCG_FN_RUN), rise);
  assign abort_edge = remote_on && pick(slot(map_table, `RCG_FN_ABORT), rise);
  assign suspend_edge = remote_on && pick(slot(map_table, `RCG_FN_SUSPEND), rise);
  assign resume_edge = remote_on && pick(slot(map_table, `RCG_FN_RESUME), rise);
  assign reset_edge = remote_on && pick(slot(map_table, `RCG_FN_RESET), rise);

  // Levels of the abort and suspend lines for the interlocks
  assign abort_lvl = pick(slot(map_table, `RCG_FN_ABORT), lvl);
  assign suspend_lvl = pick(slot(map_table, `RCG_FN_SUSPEND), lvl);

  // Program select bits are levels, weights 1 to 32
  genvar gs;
  generate
    for (gs = 0; gs < 6; gs = gs + 1) begin : g_sel
      assign prog_now[gs] = pick(slot(map_table, `RCG_FN_SEL0 + gs), lvl);
    end
  endgenerate

  // Acceptance conditions, each judged in the edge cycle only
  assign run_ok = ready_i && !error_i && !halt_active_status_i && !guard_open_status_i
    && halt_released_status_i && !suspend_lvl && !abort_lvl;
  assign suspend_ok = running_i;
  assign resume_ok = paused_i && !suspend_lvl && !abort_lvl;
  assign reset_ok = ready_i;

  // Abort is never refused
  assign any_accept = (run_edge && run_ok) || abort_edge || (suspend_edge && suspend_ok)
    || (resume_edge && resume_ok) || (reset_edge && reset_ok);
  assign any_reject = (run_edge && !run_ok) || (suspend_edge && !suspend_ok)
    || (resume_edge && !resume_ok) || (reset_edge && !reset_ok);

  // Command pulses, one cycle each
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_req_o <= 1'b0;
      abort_o <= 1'b0;
      suspend_o <= 1'b0;
      resume_o <= 1'b0;
      fault_reset_o <= 1'b0;
    end else begin
      run_req_o <= run_edge && run_ok;
      abort_o <= abort_edge;
      suspend_o <= suspend_edge && suspend_ok;
      resume_o <= resume_edge && resume_ok;
      fault_reset_o <= reset_edge && reset_ok;
    end
  end

  // Program number frozen with the accepted run edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_prog_o <= 6'h00;
    end else if (run_edge && run_ok) begin
      run_prog_o <= prog_now;
    end
  end

  // Rejected flag: set on a refused edge, cleared by an accepted one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      command_rejected_flag_o <= 1'b0;
    end else if (any_reject) begin
      command_rejected_flag_o <= 1'b1;
    end else if (any_accept) begin
      command_rejected_flag_o <= 1'b0;
    end
  end

  // Acceptance possible whenever the remote source is selected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      external_control_active_o <= 1'b0;
    end else begin
      external_control_active_o <= remote_on;
    end
  end

  // Status sources in output slot order
  assign out_src = {command_rejected_flag_o, external_control_active_o, halt_released_status_i,
    warning_i, serious_fault_status_i, guard_open_status_i, error_i, paused_i, running_i, ready_i};

  // Route each status to every pin it is mapped to
  always_comb begin
    next_dout = 16'h0000;
    for (int p = 0; p < 16; p++) begin
      for (int f = 0; f < `RCG_FN_OUT_CNT; f++) begin
        if (routes_to(slot(map_table, `RCG_FN_OUT0 + f), p) && out_src[f]) begin
          next_dout[p] = 1'b1;
        end
      end
    end
  end

  // Pins registered so they never glitch during remapping
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dout_o <= 16'h0000;
    end else begin
      dout_o <= next_dout;
    end
  end

  // Events feeding the interrupt status
  always_comb begin
    irq_evt = `RCG_IRQ_RESET_VAL;
    irq_evt[`RCG_IRQ_RUN] = run_edge && run_ok;
    irq_evt[`RCG_IRQ_ABORT] = abort_edge;
    irq_evt[`RCG_IRQ_SUSPEND] = suspend_edge && suspend_ok;
    irq_evt[`RCG_IRQ_RESUME] = resume_edge && resume_ok;
    irq_evt[`RCG_IRQ_RESET] = reset_edge && reset_ok;
    irq_evt[`RCG_IRQ_REJECT] = any_reject;
  end

  // Sticky status, cleared by a read; a new event in that cycle survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= `RCG_IRQ_RESET_VAL;
    end else if (bus_rd && !map_hit && (word_idx == `RCG_REG_IRQ_STAT)) begin
      irq_stat <= irq_evt;
    end else begin
      irq_stat <= irq_stat | irq_evt;
    end
  end

  // Level interrupt from the masked status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((irq_stat | irq_evt) & irq_mask);
    end
  end

  // Bus handshake: wait one cycle for map read data, then ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state <= BUS_IDLE;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (wb_cyc_i && wb_stb_i) begin
            bus_state <= BUS_WAIT;
          end
        end
        BUS_WAIT: begin
          bus_state <= BUS_ACK;
        end
        BUS_ACK: begin
          bus_state <= BUS_IDLE;
        end
        default: begin
          bus_state <= BUS_IDLE;
        end
      endcase
    end
  end

  // Ack marks the edge where writes land and read data is valid
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= (bus_state == BUS_WAIT);
    end
  end

  // Control and mask registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `RCG_CTRL_RESET;
      irq_mask <= `RCG_IRQ_RESET_VAL;
    end else if (bus_wr && !map_hit) begin
      if (word_idx == `RCG_REG_CTRL) begin
        ctrl <= wb_dat_i[1:0];
      end
      if (word_idx == `RCG_REG_IRQ_MASK) begin
        irq_mask <= wb_dat_i[5:0];
      end
    end
  end

  // Read multiplexer; unmapped words read zero
  always_comb begin
    next_rdata = 32'h00000000;
    if (map_hit) begin
      next_rdata[5:0] = map_rdata;
    end else begin
      case (word_idx)
        `RCG_REG_CTRL: begin
          next_rdata[1:0] = ctrl;
        end
        `RCG_REG_STATUS: begin
          next_rdata[10:0] = {command_rejected_flag_o, external_control_active_o,
            halt_released_status_i, warning_i, serious_fault_status_i, guard_open_status_i,
            halt_active_status_i, error_i, paused_i, running_i, ready_i};
          next_rdata[`RCG_STAT_PROG_LSB +: 6] = run_prog_o;
        end
        `RCG_REG_IRQ_STAT: begin
          next_rdata[5:0] = irq_stat;
        end
        `RCG_REG_IRQ_MASK: begin
          next_rdata[5:0] = irq_mask;
        end
        default: begin
          next_rdata = 32'h00000000;
        end
      endcase
    end
  end

  // Read data registered together with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_rd) begin
      wb_dat_o <= next_rdata;
    end else begin
      wb_dat_o <= 32'h00000000;
    end
  end
endmodule

/* src/rcg_map_regs.sv */
`timescale 1ns/1ps
`include "rcg_consts.svh"
module rcg_map_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Write port
  input wire logic we_i,
  input wire logic [4:0] waddr_i,
  input wire rcg_pkg::rcg_map_t wdata_i,
  // Registered read port
  input wire logic [4:0] raddr_i,
  output rcg_pkg::rcg_map_t rdata_o,
  // Whole table for the decode logic
  output logic [191:0] table_o
);
  import rcg_pkg::*;

  rcg_map_t mem [0:31];

  // Factory assignment of each function slot
  function automatic rcg_map_t def_entry(input int idx);
    case (idx)
      0: def_entry = `RCG_DEF_RUN;
      1: def_entry = `RCG_DEF_W1;
      2: def_entry = `RCG_DEF_W2;
      3: def_entry = `RCG_DEF_W4;
      7: def_entry = `RCG_DEF_ABORT;
      8: def_entry = `RCG_DEF_SUSPEND;
      9: def_entry = `RCG_DEF_RESUME;
      10: def_entry = `RCG_DEF_RESET;
      16: def_entry = `RCG_DEF_READY;
      17: def_entry = `RCG_DEF_RUNNING;
      18: def_entry = `RCG_DEF_PAUSED;
      19: def_entry = `RCG_DEF_ERROR;
      20: def_entry = `RCG_DEF_GUARD;
      21: def_entry = `RCG_DEF_SERIOUS;
      22: def_entry = `RCG_DEF_WARNING;
      23: def_entry = `RCG_DEF_RELEASED;
      default: def_entry = `RCG_MAP_UNSET;
    endcase
  endfunction

  // One entry per slot, reset to the default assignment
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_ent
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          mem[g] <= def_entry(g);
        end else if (we_i && (waddr_i == 5'(g))) begin
          mem[g] <= wdata_i;
        end
      end
      assign table_o[g*6 +: 6] = mem[g];
    end
  endgenerate

  // Read data held in a register for the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= `RCG_MAP_UNSET;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule

/* src/rcg_pkg.sv */
package rcg_pkg;
  typedef logic [5:0] rcg_map_t;
  typedef logic [23:0] rcg_din_t;
  typedef logic [15:0] rcg_dout_t;
  typedef logic [5:0] rcg_prog_t;
  typedef logic [5:0] rcg_irq_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_ACK} rcg_bus_e;
endpackage

/* tb/rcg_gate_sva.sv */
`timescale 1ns/1ps
module rcg_gate_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Lines and status in
  input wire rcg_pkg::rcg_din_t din_i,
  input wire logic ready_i,
  input wire logic running_i,
  input wire logic error_i,
  input wire logic halt_active_status_i,
  input wire logic guard_open_status_i,
  input wire logic halt_released_status_i,
  // Outputs watched
  input wire rcg_pkg::rcg_dout_t dout_o,
  input wire logic run_req_o,
  input wire rcg_pkg::rcg_prog_t run_prog_o,
  input wire logic abort_o,
  input wire logic suspend_o,
  input wire logic resume_o,
  input wire logic fault_reset_o,
  input wire logic external_control_active_o,
  input wire logic command_rejected_flag_o
);
  import rcg_pkg::*;
  logic run_ok;
  logic any_cmd;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Run interlock, judged over the whole synchroniser delay
  assign run_ok = external_control_active_o && ready_i && !error_i && !halt_active_status_i &&
                  !guard_open_status_i && halt_released_status_i && din_i[5:4] == 2'h0;
  assign any_cmd = run_req_o | abort_o | suspend_o | resume_o | fault_reset_o;
  sequence run_edge_ok;
    $rose(din_i[0]) ##0 run_ok [*4];
  endsequence
  sequence run_edge_bad;
    $rose(din_i[0]) ##0 (external_control_active_o && !ready_i && din_i[5:4] == 2'h0) [*4];
  endsequence
  run_accept_a: assert property (run_edge_ok |-> run_req_o)
    else $error("run edge with interlocks met gave no run pulse");
  run_refuse_a: assert property (run_edge_bad |-> !run_req_o && command_rejected_flag_o)
    else $error("refused run edge not flagged");
  abort_any_a: assert property ($rose(din_i[4]) ##0 external_control_active_o [*4] |-> abort_o)
    else $error("abort edge not acted on");
  suspend_ok_a: assert property ($rose(din_i[5]) ##0 (external_control_active_o && running_i) [*4]
    |-> suspend_o)
    else $error("suspend edge while running not acted on");
  reset_ok_a: assert property ($rose(din_i[7]) ##0 (external_control_active_o && ready_i) [*4]
    |-> fault_reset_o)
    else $error("reset edge while ready not acted on");
  remote_gate_a: assert property ((!external_control_active_o) [*4] |-> !any_cmd)
    else $error("command issued while local control");
  run_once_a: assert property (run_req_o |=> !run_req_o)
    else $error("run pulse longer than one cycle");
  prog_capture_a: assert property (run_req_o |-> run_prog_o[2:0] == $past(din_i[3:1], 3))
    else $error("program number not taken with run");
  prog_hold_a: assert property (!run_req_o |-> $stable(run_prog_o))
    else $error("program number changed without run");
  dout_track_a: assert property (!$past(rst_i) |-> dout_o[0] == $past(ready_i))
    else $error("ready output does not follow status");
endmodule
bind rcg_gate rcg_gate_sva chk_u (.clk_i(clk_i), .rst_i(rst_i), .din_i(din_i), .ready_i(ready_i),
  .running_i(running_i), .error_i(error_i), .halt_active_status_i(halt_active_status_i),
  .guard_open_status_i(guard_open_status_i), .halt_released_status_i(halt_released_status_i),
  .dout_o(dout_o), .run_req_o(run_req_o), .run_prog_o(run_prog_o), .abort_o(abort_o),
  .suspend_o(suspend_o), .resume_o(resume_o), .fault_reset_o(fault_reset_o),
  .external_control_active_o(external_control_active_o),
  .command_rejected_flag_o(command_rejected_flag_o));

/* tb/rcg_seq_model.sv */
`timescale 1ns/1ps
module rcg_seq_model (
  // Clock
  input wire logic clk_i,
  // Discrete lines toward the gate
  output rcg_pkg::rcg_din_t din_o
);
  import rcg_pkg::*;
  initial din_o = '0;
  // Lines move just after an edge; callers lower a line between strikes so each rise is new
  task automatic drive(input int idx, input logic val);
    @(posedge clk_i);
    din_o[idx] <= val;
  endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import rcg_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, run_req_o, abort_o, suspend_o, resume_o, fault_reset_o;
  logic external_control_active_o, command_rejected_flag_o, irq_o;
  rcg_din_t din;
  rcg_dout_t dout_o;
  rcg_prog_t run_prog_o;
  // Status bits: ready, running, paused, error, halt, guard, serious, warning, released
  logic [8:0] st = 9'h000;
  int miscompares = 0;
  int cmp_count = 0;
  always #2.5 clk_i = ~clk_i;
  rcg_seq_model seq_u (.clk_i(clk_i), .din_o(din));
  rcg_gate dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .din_i(din), .dout_o(dout_o), .ready_i(st[0]),
    .running_i(st[1]), .paused_i(st[2]), .error_i(st[3]), .halt_active_status_i(st[4]),
    .guard_open_status_i(st[5]), .serious_fault_status_i(st[6]), .warning_i(st[7]),
    .halt_released_status_i(st[8]), .run_req_o(run_req_o), .run_prog_o(run_prog_o),
    .abort_o(abort_o), .suspend_o(suspend_o), .resume_o(resume_o), .fault_reset_o(fault_reset_o),
    .external_control_active_o(external_control_active_o),
    .command_rejected_flag_o(command_rejected_flag_o), .irq_o(irq_o));
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Classic single cycle; slave latency is not assumed, only bounded
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    q = '0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (wb_ack_o === 1'b1) begin
      q = wb_dat_o;
    end else begin
      miscompares++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  // Strike one line and gather every command pulse within the answer window
  task automatic cmd(input int line, input logic [4:0] exp_vec, input logic exp_flag);
    logic [4:0] seen;
    seen = '0;
    seq_u.drive(line, 1'b1);
    repeat (8) begin
      @(posedge clk_i);
      seen |= {fault_reset_o, resume_o, suspend_o, abort_o, run_req_o};
    end
    seq_u.drive(line, 1'b0);
    repeat (3) @(posedge clk_i);
    chk(32'(seen), 32'(exp_vec));
    chk(32'(command_rejected_flag_o), 32'(exp_flag));
  endtask
  task automatic t_defaults;
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h0C, 32'h0);
    rd_chk(8'h80, 32'h20);
    rd_chk(8'h9C, 32'h24);
    rd_chk(8'hA8, 32'h27);
    rd_chk(8'hC0, 32'h20);
    rd_chk(8'hD0, 32'h25);
    rd_chk(8'hDC, 32'h28);
    rd_chk(8'hE4, 32'h0);
    rd_chk(8'h40, 32'h0);
    chk(32'(dout_o), 32'h0101);
  endtask
  task automatic t_remote;
    cmd(0, 5'h00, 1'b0);
    chk(32'(external_control_active_o), 32'h0);
    wr(8'h00, 32'h3);
    repeat (3) @(posedge clk_i);
    chk(32'(external_control_active_o), 32'h1);
  endtask
  task automatic t_run;
    wr(8'h90, 32'h28);
    seq_u.drive(1, 1'b1);
    seq_u.drive(3, 1'b1);
    seq_u.drive(8, 1'b1);
    cmd(0, 5'h01, 1'b0);
    chk(32'(run_prog_o), 32'h0D);
    // Status word: ready, released, external control, last program
    rd_chk(8'h04, 32'h000D0301);
  endtask
  task automatic t_refuse;
    wr(8'h0C, 32'h20);
    st <= 9'h100;
    cmd(0, 5'h00, 1'b1);
    chk(32'(irq_o), 32'h1);
    rd_chk(8'h08, 32'h21);
    repeat (2) @(posedge clk_i);
    chk(32'(irq_o), 32'h0);
    // Ready but guard open, then ready but halt active: run still refused
    st <= 9'h121;
    cmd(0, 5'h00, 1'b1);
    chk(32'(dout_o), 32'h0121);
    rd_chk(8'h08, 32'h20);
    st <= 9'h111;
    cmd(0, 5'h00, 1'b1);
    rd_chk(8'h08, 32'h20);
    rd_chk(8'h0C, 32'h20);
  endtask
  task automatic t_abort_suspend;
    cmd(4, 5'h02, 1'b0);
    cmd(5, 5'h00, 1'b1);
    st <= 9'h102;
    cmd(5, 5'h04, 1'b0);
  endtask
  task automatic t_resume;
    st <= 9'h104;
    seq_u.drive(5, 1'b1);
    cmd(6, 5'h00, 1'b1);
    seq_u.drive(5, 1'b0);
    repeat (3) @(posedge clk_i);
    cmd(6, 5'h08, 1'b0);
  endtask
  task automatic t_reset;
    st <= 9'h108;
    cmd(7, 5'h00, 1'b1);
    // Ready now set beside the error, so the reset edge is accepted
    st <= 9'h109;
    cmd(7, 5'h10, 1'b0);
  endtask
  task automatic t_remap;
    wr(8'hA4, 32'h2C);
    wr(8'hE4, 32'h24);
    st <= 9'h105;
    cmd(6, 5'h00, 1'b0);
    cmd(12, 5'h08, 1'b0);
    chk(32'(dout_o), 32'h0105);
    st <= 9'h101;
    cmd(12, 5'h00, 1'b1);
    chk(32'(dout_o[4]), 32'h1);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    st <= 9'h101;
    t_defaults();
    t_remote();
    t_run();
    t_refuse();
    t_abort_suspend();
    t_resume();
    t_reset();
    t_remap();
    finish_test();
  end
endmodule
